// File: rtl/servo_status_pkg.sv
package servo_status_pkg;

    // Value widths
    localparam int POS_W = 24;
    localparam int SPD_W = 16;
    localparam int TRQ_W = 16;
    localparam int IDX_W = 6;
    localparam int CODE_W = 3;
    localparam int REV_W = 16;

    // Register offsets
    localparam logic [3:0] ADDR_IN_POS = 4'h0;
    localparam logic [3:0] ADDR_NEAR_POS = 4'h1;
    localparam logic [3:0] ADDR_SPD_AGREE = 4'h2;
    localparam logic [3:0] ADDR_TURN_LVL = 4'h3;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;

    // Control register field positions
    localparam int CTRL_INV_A = 0;
    localparam int CTRL_INV_B = 1;
    localparam int CTRL_GPO_A = 2;
    localparam int CTRL_GPO_B = 3;
    localparam int CTRL_GPO_C = 4;
    localparam int CTRL_W = 5;

    // Reset values
    localparam logic [POS_W-1:0] RST_IN_POS = 24'h00000a;
    localparam logic [POS_W-1:0] RST_NEAR_POS = 24'h000064;
    localparam logic [SPD_W-1:0] RST_SPD_AGREE = 16'h000a;
    localparam logic [SPD_W-1:0] RST_TURN_LVL = 16'h0014;
    localparam logic [CTRL_W-1:0] RST_CTRL = 5'h00;

    // Serial bit period of the revolution count output
    localparam int SER_BIT_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int SER_BIT_CYC = (SER_BIT_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic in_position;
        logic near_position;
        logic speed_agree;
        logic turning;
        logic torque_limited;
        logic speed_limited;
        logic abs_valid;
        logic drive_ready;
        logic warning;
        logic alarm;
        logic home_done;
        logic in_motion;
        logic in_dwell;
        logic seq_done;
    } status_flags_s;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic index;
    } enc_pulses_s;

endpackage

// File: rtl/revolution_serial_tx.sv
`timescale 1ns/1ps
module revolution_serial_tx (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [servo_status_pkg::REV_W-1:0] i_count,
    output logic o_busy,
    output logic o_serial
);
    typedef enum logic [1:0] {IDLE, START, DATA, STOP} tx_state_e;
    tx_state_e state;
    logic [servo_status_pkg::REV_W-1:0] shift;
    logic [15:0] tick;
    logic [4:0] bit_cnt;
    logic tick_end;

    assign tick_end = (tick == 16'(servo_status_pkg::SER_BIT_CYC - 1));
    assign o_busy = (state != IDLE);

    // Bit timer, restarted on every state step
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            tick <= 16'h0000;
        end else if (state == IDLE || tick_end) begin
            tick <= 16'h0000;
        end else begin
            tick <= tick + 16'h0001;
        end
    end

    // Frame: low start bit, LSB first data, high stop bit
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= IDLE;
            shift <= '0;
            bit_cnt <= 5'h00;
            o_serial <= 1'b1;
        end else begin
            unique case (state)
                IDLE: begin
                    o_serial <= 1'b1;
                    if (i_start) begin
                        shift <= i_count;
                        state <= START;
                        o_serial <= 1'b0;
                    end
                end
                START: begin
                    if (tick_end) begin
                        state <= DATA;
                        bit_cnt <= 5'h00;
                        o_serial <= shift[0];
                    end
                end
                DATA: begin
                    if (tick_end) begin
                        if (bit_cnt == 5'(servo_status_pkg::REV_W - 1)) begin
                            state <= STOP;
                            o_serial <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 5'h01;
                            shift <= {1'b0, shift[servo_status_pkg::REV_W-1:1]};
                            o_serial <= shift[1];
                        end
                    end
                end
                STOP: begin
                    if (tick_end) begin
                        state <= IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// File: rtl/servo_status_output_logic.sv
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Alarm sequence output follows any active servo alarm in every mode.
// - In-position flag while absolute position error within in-position range.
// - Near-position flag while position error within its own separate range.
// - Speed agree flag while command minus motor speed magnitude within range.
// - Turning flag while motor speed magnitude exceeds the turning level.
// - Torque limit flag while output torque reached current torque limit.
// - Speed limit flag while motor speed reached current speed limit.
// - Absolute valid flag only with absolute encoder fitted and data valid.
// - Drive ready flag while servo off and prepared to run; the code also holds it off while a servo alarm is active.
// - Warning flag on any servo warning, apart from alarm.
// - Homing done flag in indexing mode after return to home completes.
// - In-motion flag in indexing mode while a move is in progress.
// - Index number in use shown as six binary bits in indexing mode.
// - Sequence done flag in indexing mode once index movement finished.
// - Alarm type encoded onto 3-bit alarm code group during servo alarm.
// - Alarm code suppressed if any code line serves as general output.
// - Encoder A, B, index passed out; A and B inverted when selected.
// - Revolution count sent serially when absolute encoder is in use.
// - Dedicated alarm monitor output active whenever a servo alarm exists.
module servo_status_output_logic (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // Register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Drive state inputs
    input wire logic signed [servo_status_pkg::POS_W-1:0] i_pos_error,
    input wire logic signed [servo_status_pkg::SPD_W-1:0] i_speed_cmd,
    input wire logic signed [servo_status_pkg::SPD_W-1:0] i_motor_speed,
    input wire logic [servo_status_pkg::TRQ_W-1:0] i_torque_abs,
    input wire logic [servo_status_pkg::TRQ_W-1:0] i_torque_limit,
    input wire logic [servo_status_pkg::SPD_W-1:0] i_speed_limit,
    input wire logic i_abs_encoder_fitted,
    input wire logic i_abs_data_valid,
    input wire logic i_servo_on,
    input wire logic i_prepared,
    input wire logic i_warning,
    input wire logic i_alarm,
    input wire logic [servo_status_pkg::CODE_W-1:0] i_alarm_type,
    input wire logic i_indexing_mode,
    input wire logic i_home_done,
    input wire logic i_move_active,
    input wire logic i_dwell_active,
    input wire logic i_seq_done,
    input wire logic [servo_status_pkg::IDX_W-1:0] i_index_num,
    input wire servo_status_pkg::enc_pulses_s i_enc,
    input wire logic i_rev_send,
    input wire logic [servo_status_pkg::REV_W-1:0] i_rev_count,
    // Status outputs
    output servo_status_pkg::status_flags_s o_flags,
    output logic [servo_status_pkg::IDX_W-1:0] o_index_num,
    output logic [servo_status_pkg::CODE_W-1:0] o_alarm_code,
    output logic o_alarm_monitor,
    output servo_status_pkg::enc_pulses_s o_enc,
    output logic o_rev_serial,
    output logic o_rev_busy
);
    logic [servo_status_pkg::POS_W-1:0] in_position_range_setting;
    logic [servo_status_pkg::POS_W-1:0] near_position_range_setting;
    logic [servo_status_pkg::SPD_W-1:0] speed_agree_range_setting;
    logic [servo_status_pkg::SPD_W-1:0] turning_level_setting;
    logic [servo_status_pkg::CTRL_W-1:0] ctrl;
    logic [servo_status_pkg::POS_W-1:0] pos_err_abs;
    logic [servo_status_pkg::SPD_W-1:0] spd_abs;
    logic signed [servo_status_pkg::SPD_W:0] spd_diff;
    logic [servo_status_pkg::SPD_W:0] spd_diff_abs;
    logic code_lines_reassigned;
    servo_status_pkg::status_flags_s next_flags;

    // Magnitudes; the diff is one bit wider so it cannot wrap
    assign pos_err_abs = i_pos_error[servo_status_pkg::POS_W-1] ? -i_pos_error : i_pos_error;
    assign spd_abs = i_motor_speed[servo_status_pkg::SPD_W-1] ? -i_motor_speed : i_motor_speed;
    assign spd_diff = {i_speed_cmd[servo_status_pkg::SPD_W-1], i_speed_cmd}
        - {i_motor_speed[servo_status_pkg::SPD_W-1], i_motor_speed};
    assign spd_diff_abs = spd_diff[servo_status_pkg::SPD_W] ? -spd_diff : spd_diff;
    assign code_lines_reassigned = ctrl[servo_status_pkg::CTRL_GPO_A]
        | ctrl[servo_status_pkg::CTRL_GPO_B] | ctrl[servo_status_pkg::CTRL_GPO_C];

    // Register writes
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            in_position_range_setting <= servo_status_pkg::RST_IN_POS;
            near_position_range_setting <= servo_status_pkg::RST_NEAR_POS;
            speed_agree_range_setting <= servo_status_pkg::RST_SPD_AGREE;
            turning_level_setting <= servo_status_pkg::RST_TURN_LVL;
            ctrl <= servo_status_pkg::RST_CTRL;
        end else if (i_wr) begin
            unique case (i_addr)
                servo_status_pkg::ADDR_IN_POS: begin
                    in_position_range_setting <= i_wdata[servo_status_pkg::POS_W-1:0];
                end
                servo_status_pkg::ADDR_NEAR_POS: begin
                    near_position_range_setting <= i_wdata[servo_status_pkg::POS_W-1:0];
                end
                servo_status_pkg::ADDR_SPD_AGREE: begin
                    speed_agree_range_setting <= i_wdata[servo_status_pkg::SPD_W-1:0];
                end
                servo_status_pkg::ADDR_TURN_LVL: begin
                    turning_level_setting <= i_wdata[servo_status_pkg::SPD_W-1:0];
                end
                servo_status_pkg::ADDR_CTRL: begin
                    ctrl <= i_wdata[servo_status_pkg::CTRL_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 32'h00000000;
        end else if (i_rd) begin
            unique case (i_addr)
                servo_status_pkg::ADDR_IN_POS: o_rdata <= 32'(in_position_range_setting);
                servo_status_pkg::ADDR_NEAR_POS: o_rdata <= 32'(near_position_range_setting);
                servo_status_pkg::ADDR_SPD_AGREE: o_rdata <= 32'(speed_agree_range_setting);
                servo_status_pkg::ADDR_TURN_LVL: o_rdata <= 32'(turning_level_setting);
                servo_status_pkg::ADDR_CTRL: o_rdata <= 32'(ctrl);
                servo_status_pkg::ADDR_STATUS: o_rdata <= 32'(o_flags);
                default: o_rdata <= 32'h00000000;
            endcase
        end else begin
            o_rdata <= 32'h00000000;
        end
    end

    // Flag conditions; index flags gated by indexing mode
    always_comb begin
        next_flags = '0;
        next_flags.alarm = i_alarm;
        next_flags.in_position = (pos_err_abs <= in_position_range_setting);
        next_flags.near_position = (pos_err_abs <= near_position_range_setting);
        next_flags.speed_agree = (spd_diff_abs <= {1'b0, speed_agree_range_setting});
        next_flags.turning = (spd_abs > turning_level_setting);
        next_flags.torque_limited = (i_torque_abs >= i_torque_limit);
        next_flags.speed_limited = (spd_abs >= i_speed_limit);
        next_flags.abs_valid = i_abs_encoder_fitted & i_abs_data_valid;
        next_flags.drive_ready = ~i_servo_on & i_prepared & ~i_alarm;
        next_flags.warning = i_warning;
        next_flags.home_done = i_indexing_mode & i_home_done;
        next_flags.in_motion = i_indexing_mode & i_move_active;
        next_flags.in_dwell = i_indexing_mode & i_dwell_active;
        next_flags.seq_done = i_indexing_mode & i_seq_done;
    end

    // Registered status; all clear under reset
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_flags <= '0;
            o_index_num <= '0;
        end else begin
            o_flags <= next_flags;
            o_index_num <= i_indexing_mode ? i_index_num : '0;
        end
    end

    // Alarm code and monitor; code off when any line is a general output
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_alarm_code <= '0;
            o_alarm_monitor <= 1'b0;
        end else begin
            o_alarm_code <= (i_alarm && !code_lines_reassigned) ? i_alarm_type : '0;
            o_alarm_monitor <= i_alarm;
        end
    end

    // Encoder pass-through, one flop for clean edges
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_enc <= '0;
        end else begin
            o_enc.phase_a <= i_enc.phase_a ^ ctrl[servo_status_pkg::CTRL_INV_A];
            o_enc.phase_b <= i_enc.phase_b ^ ctrl[servo_status_pkg::CTRL_INV_B];
            o_enc.index <= i_enc.index;
        end
    end

    // Only absolute encoders have a count worth sending
    revolution_serial_tx u_rev_tx (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .i_start(i_rev_send & i_abs_encoder_fitted),
        .i_count(i_rev_count),
        .o_busy(o_rev_busy),
        .o_serial(o_rev_serial)
    );

    // Outputs lag reset release by one edge, so the in-position check skips that edge
    property p_alarm_follow;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_resetn && i_alarm) |=> (o_flags.alarm && o_alarm_monitor);
    endproperty
    a_alarm_follow: assert property (p_alarm_follow) else $error("alarm not shown");

    property p_in_pos;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        ($past(i_resetn) && i_resetn)
            |-> $past(pos_err_abs <= in_position_range_setting) == o_flags.in_position;
    endproperty
    a_in_pos: assert property (p_in_pos) else $error("in-position wrong");

    property p_turning;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_flags.turning |-> $past(spd_abs) > $past(turning_level_setting);
    endproperty
    a_turning: assert property (p_turning) else $error("turning wrong");

    property p_abs_valid;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_flags.abs_valid |-> $past(i_abs_encoder_fitted) && $past(i_abs_data_valid);
    endproperty
    a_abs_valid: assert property (p_abs_valid) else $error("abs valid wrong");

    property p_ready;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        o_flags.drive_ready |-> !$past(i_servo_on);
    endproperty
    a_ready: assert property (p_ready) else $error("ready while on");

    property p_idx_gate;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !i_indexing_mode |=> (o_index_num == '0) && !o_flags.in_motion && !o_flags.in_dwell;
    endproperty
    a_idx_gate: assert property (p_idx_gate) else $error("index out of mode");

    property p_code_supp;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        code_lines_reassigned |=> o_alarm_code == '0;
    endproperty
    a_code_supp: assert property (p_code_supp) else $error("code not hidden");

    property p_code_out;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (i_resetn && i_alarm && !code_lines_reassigned)
            |=> o_alarm_code == $past(i_alarm_type);
    endproperty
    a_code_out: assert property (p_code_out) else $error("code wrong");

    property p_enc_inv;
        @(posedge i_clk_sys) disable iff (!i_resetn)
        i_resetn |=> o_enc.phase_a
            == ($past(i_enc.phase_a) ^ $past(ctrl[servo_status_pkg::CTRL_INV_A]));
    endproperty
    a_enc_inv: assert property (p_enc_inv) else $error("phase a wrong");
endmodule

// File: dv/host_status_rx.sv
`timescale 1ns/1ps
// Host side receiver for the revolution count frame
module host_status_rx (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_serial,
    output logic [15:0] o_word,
    output logic o_err,
    output logic [7:0] o_frames
);
    localparam int BIT_CYC = servo_status_pkg::SER_BIT_CYC;
    int cnt;
    int bitn;
    logic busy;
    logic [15:0] shreg;

    // Samples at mid-bit, so a bit edge off by a cycle still decodes
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            busy <= 1'b0;
            cnt <= 0;
            bitn <= 0;
            shreg <= 16'h0000;
            o_word <= 16'h0000;
            o_err <= 1'b0;
            o_frames <= 8'h00;
        end else if (!busy) begin
            if (!i_serial) begin
                busy <= 1'b1;
                cnt <= BIT_CYC / 2;
                bitn <= 0;
            end
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end else begin
            cnt <= BIT_CYC - 1;
            bitn <= bitn + 1;
            if (bitn == 0 && i_serial) begin
                o_err <= 1'b1;
            end
            if (bitn >= 1 && bitn <= 16) begin
                shreg <= {i_serial, shreg[15:1]};
            end
            if (bitn == 17) begin
                busy <= 1'b0;
                o_word <= shreg;
                o_frames <= o_frames + 8'h01;
                if (!i_serial) begin
                    o_err <= 1'b1;
                end
            end
        end
    end
endmodule

// File: dv/servo_status_output_logic_test.sv
`timescale 1ns/1ps
module servo_status_output_logic_test;
    typedef struct packed {
        logic signed [23:0] pe;
        logic signed [15:0] sc;
        logic signed [15:0] ms;
        logic [15:0] tq, tl, sl;
        logic [10:0] bits;
        logic [13:0] fl;
    } row_s;
    row_s rows [4];
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic [3:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic i_wr, i_rd;
    logic signed [23:0] i_pos_error;
    logic signed [15:0] i_speed_cmd, i_motor_speed;
    logic [15:0] i_torque_abs, i_torque_limit, i_speed_limit, i_rev_count, rx_word;
    logic i_abs_encoder_fitted, i_abs_data_valid, i_servo_on, i_prepared, i_warning, i_alarm;
    logic i_indexing_mode, i_home_done, i_move_active, i_dwell_active, i_seq_done;
    logic [2:0] i_alarm_type, o_alarm_code, e;
    logic [5:0] i_index_num, o_index_num;
    servo_status_pkg::enc_pulses_s i_enc, o_enc;
    servo_status_pkg::status_flags_s o_flags;
    logic i_rev_send, o_alarm_monitor, o_rev_serial, o_rev_busy, rx_err;
    logic [7:0] rx_frames;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    servo_status_output_logic DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_pos_error(i_pos_error), .i_speed_cmd(i_speed_cmd), .i_motor_speed(i_motor_speed),
        .i_torque_abs(i_torque_abs), .i_torque_limit(i_torque_limit),
        .i_speed_limit(i_speed_limit), .i_abs_encoder_fitted(i_abs_encoder_fitted),
        .i_abs_data_valid(i_abs_data_valid), .i_servo_on(i_servo_on), .i_prepared(i_prepared),
        .i_warning(i_warning), .i_alarm(i_alarm), .i_alarm_type(i_alarm_type),
        .i_indexing_mode(i_indexing_mode), .i_home_done(i_home_done),
        .i_move_active(i_move_active), .i_dwell_active(i_dwell_active), .i_seq_done(i_seq_done),
        .i_index_num(i_index_num), .i_enc(i_enc), .i_rev_send(i_rev_send),
        .i_rev_count(i_rev_count), .o_flags(o_flags), .o_index_num(o_index_num),
        .o_alarm_code(o_alarm_code), .o_alarm_monitor(o_alarm_monitor), .o_enc(o_enc),
        .o_rev_serial(o_rev_serial), .o_rev_busy(o_rev_busy));

    host_status_rx host (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_serial(o_rev_serial),
        .o_word(rx_word), .o_err(rx_err), .o_frames(rx_frames));

    // Clock and hang guard; the longest scenario is one 1800-cycle frame
    always #5 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 v = o_rdata;
    endtask

    task automatic settle();
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        {i_addr, i_wdata, i_wr, i_rd, i_pos_error, i_speed_cmd, i_motor_speed} = '0;
        {i_torque_abs, i_torque_limit, i_speed_limit, i_rev_count, i_rev_send} = '0;
        {i_abs_encoder_fitted, i_abs_data_valid, i_servo_on, i_prepared, i_warning} = '0;
        {i_alarm, i_alarm_type, i_indexing_mode, i_home_done, i_move_active} = '0;
        {i_dwell_active, i_seq_done, i_index_num, i_enc} = '0;
        // Boundary rows: each threshold sits just on or just past its edge
        rows[0] = '{24'sd10, 16'sd100, 16'sd90, 5, 5, 90, 11'b11010011010, 14'b11111111001010};
        rows[1] = '{-24'sd11, 16'sd0, -16'sd20, 4, 5, 21, 11'b10111010101, 14'b01000000100101};
        rows[2] = '{-24'sd100, -16'sd30, -16'sd21, 9, 8, 100, 11'b01010100000, 14'b01111000010000};
        rows[3] = '{24'sd101, 16'sd10, -16'sd1, 0, 1, 1, 11'b00000000000, 14'b00000100000000};
        repeat (2) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(servo_status_pkg::ADDR_CTRL, d);
        chk("ctrl_rst", servo_status_pkg::RST_CTRL, d);
        rd(servo_status_pkg::ADDR_IN_POS, d);
        chk("in_pos_rst", servo_status_pkg::RST_IN_POS, d);
        rd(servo_status_pkg::ADDR_NEAR_POS, d);
        chk("near_rst", servo_status_pkg::RST_NEAR_POS, d);
        rd(servo_status_pkg::ADDR_TURN_LVL, d);
        chk("turn_rst", servo_status_pkg::RST_TURN_LVL, d);
        wr(servo_status_pkg::ADDR_SPD_AGREE, 32'hffff1234);
        rd(servo_status_pkg::ADDR_SPD_AGREE, d);
        chk("agree_rw", 32'h00001234, d);
        wr(servo_status_pkg::ADDR_SPD_AGREE, 32'h0000000a);
        for (int i = 0; i < 4; i++) begin
            @(posedge i_clk_sys);
            i_pos_error <= rows[i].pe;
            i_speed_cmd <= rows[i].sc;
            i_motor_speed <= rows[i].ms;
            i_torque_abs <= rows[i].tq;
            i_torque_limit <= rows[i].tl;
            i_speed_limit <= rows[i].sl;
            {i_abs_encoder_fitted, i_abs_data_valid, i_servo_on, i_prepared, i_warning, i_alarm,
                i_indexing_mode, i_home_done, i_move_active, i_dwell_active,
                i_seq_done} <= rows[i].bits;
            i_alarm_type <= 3'(i + 5);
            i_index_num <= 6'(i + 42);
            @(posedge i_clk_sys);
            #1;
            chk("flags", rows[i].fl, o_flags);
            chk("code", rows[i].bits[5] ? 3'(i + 5) : 3'h0, o_alarm_code);
            chk("monitor", rows[i].bits[5], o_alarm_monitor);
            chk("index", rows[i].bits[4] ? 6'(i + 42) : 6'h00, o_index_num);
        end
        wr(servo_status_pkg::ADDR_STATUS, 32'h00003fff);
        rd(servo_status_pkg::ADDR_STATUS, d);
        chk("status", 32'h00000100, d);
        rd(4'h9, d);
        chk("unmapped", 32'h0, d);
        // Encoder pass-through under every inversion setting
        for (int c = 0; c < 4; c++) begin
            wr(servo_status_pkg::ADDR_CTRL, 32'(c));
            for (int k = 0; k < 8; k++) begin
                e = 3'(k);
                @(posedge i_clk_sys);
                i_enc <= e;
                settle();
                chk("enc", e ^ {c[0], c[1], 1'b0}, o_enc);
            end
        end
        // Any alarm line lent out as a general output silences the code
        @(posedge i_clk_sys);
        i_alarm <= 1'b1;
        i_alarm_type <= 3'h6;
        for (int k = 0; k < 3; k++) begin
            wr(servo_status_pkg::ADDR_CTRL, 32'h4 << k);
            settle();
            chk("code_gpo", 32'h0, o_alarm_code);
            chk("monitor_gpo", 32'h1, o_alarm_monitor);
        end
        wr(servo_status_pkg::ADDR_CTRL, 32'h0);
        settle();
        chk("code_back", 32'h6, o_alarm_code);
        // Serial frame, with a second start while busy that must be dropped
        @(posedge i_clk_sys);
        i_rev_send <= 1'b1;
        @(posedge i_clk_sys);
        i_rev_send <= 1'b0;
        #1;
        chk("no_abs", 32'h0, o_rev_busy);
        @(posedge i_clk_sys);
        i_abs_encoder_fitted <= 1'b1;
        i_rev_count <= 16'hb38d;
        i_rev_send <= 1'b1;
        @(posedge i_clk_sys);
        i_rev_send <= 1'b0;
        repeat (500) @(posedge i_clk_sys);
        i_rev_count <= 16'h1111;
        i_rev_send <= 1'b1;
        @(posedge i_clk_sys);
        i_rev_send <= 1'b0;
        #1;
        chk("busy", 32'h1, o_rev_busy);
        for (int t = 0; t < 2000 && o_rev_busy !== 1'b0; t++)
            @(posedge i_clk_sys);
        repeat (300) @(posedge i_clk_sys);
        #1;
        chk("rx_word", 32'hb38d, rx_word);
        chk("rx_frames", 32'h1, rx_frames);
        chk("rx_err", 32'h0, rx_err);
        chk("idle", 32'h1, o_rev_serial);
        // Move a setting off its reset value so the reset below is visible
        wr(servo_status_pkg::ADDR_SPD_AGREE, 32'h00000077);
        // Reset in mid-run with alarm and flags active
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        #1;
        chk("rst_flags", 32'h0, o_flags);
        chk("rst_code", 32'h0, o_alarm_code);
        chk("rst_mon", 32'h0, o_alarm_monitor);
        chk("rst_ser", 32'h1, o_rev_serial);
        @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        rd(servo_status_pkg::ADDR_SPD_AGREE, d);
        chk("agree_rst", servo_status_pkg::RST_SPD_AGREE, d);
        summarize();
    end
endmodule
